// [instruction_word_decoder.sv]
`timescale 1ns/100ps
module instruction_word_decoder (
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire logic [15:0] INSN_IN,
  input wire logic INSN_VALID_IN,
  input wire logic [3:0] BANK_SELECT_IN,
  input wire logic INDEXED_IN,
  input wire logic [11:0] SRC_PTR_IN,
  input wire logic [11:0] DST_PTR_IN,
  output insn_decode_pkg::decoded_t DEC_OUT,
  output logic DEC_VALID_OUT
);

  insn_decode_pkg::core_state_t cur;
  insn_decode_pkg::core_state_t next_cur;
  insn_decode_pkg::class_t cls;
  logic second_word;

  insn_class_lookup u_lookup (
    .word_in(INSN_IN),
    .cls_out(cls)
  );

  // Common fields of a first word
  function automatic insn_decode_pkg::decoded_t base_fields(
    input logic [15:0] w,
    input logic [3:0] bank
  );
    insn_decode_pkg::decoded_t d;
    d = '0;
    d.opcode = w[insn_decode_pkg::OPC_HI:insn_decode_pkg::OPC_LO]; // RULE1
    d.dest_file = w[insn_decode_pkg::DEST_POS]; // RULE2
    d.bank_sel_en = w[insn_decode_pkg::BANK_POS]; // RULE3
    d.fast = w[insn_decode_pkg::FAST_POS];
    d.file_addr = w[insn_decode_pkg::FILE_HI:0]; // RULE1
    if (w[insn_decode_pkg::BANK_POS]) begin
      d.eff_addr = {bank, w[insn_decode_pkg::FILE_HI:0]}; // RULE3
    end else begin
      d.eff_addr = {insn_decode_pkg::BANK_ACCESS,
                    w[insn_decode_pkg::FILE_HI:0]}; // RULE3
    end
    d.bit_pos = w[insn_decode_pkg::BITPOS_HI:insn_decode_pkg::BITPOS_LO]; // RULE4
    d.literal = w[insn_decode_pkg::FILE_HI:0]; // RULE5
    d.target = {12'h000, w[insn_decode_pkg::FILE_HI:0]};
    return d;
  endfunction : base_fields

  assign second_word = INSN_IN[15:insn_decode_pkg::NIB_LO]
                       == insn_decode_pkg::NIB_SECOND;

  always_comb begin
    next_cur = cur;
    next_cur.dec_valid = 1'b0;
    if (INSN_VALID_IN) begin
      if (cur.phase == insn_decode_pkg::ph_second && second_word) begin
        next_cur.phase = insn_decode_pkg::ph_first;
        next_cur.dec_valid = 1'b1;
        next_cur.dec = base_fields(cur.first_word, BANK_SELECT_IN);
        next_cur.dec.op = cur.pend_op;
        next_cur.dec.target = {INSN_IN[insn_decode_pkg::ADDR12_HI:0],
                               cur.first_word[insn_decode_pkg::FILE_HI:0]}; // RULE6
        if (INDEXED_IN) begin
          next_cur.dec.src_addr = SRC_PTR_IN + {insn_decode_pkg::OFFS_PAD,
            cur.first_word[insn_decode_pkg::OFFS_HI:0]}; // RULE8
          next_cur.dec.dst_addr = DST_PTR_IN + {insn_decode_pkg::OFFS_PAD,
            INSN_IN[insn_decode_pkg::OFFS_HI:0]}; // RULE8
        end else begin
          next_cur.dec.src_addr =
            cur.first_word[insn_decode_pkg::ADDR12_HI:0]; // RULE7
          next_cur.dec.dst_addr = INSN_IN[insn_decode_pkg::ADDR12_HI:0]; // RULE7
        end
        next_cur.dec.flag_mask = insn_decode_pkg::FLAGS_NONE; // RULE7
        next_cur.dec.can_skip = 1'b0;
        next_cur.dec.cycles = insn_decode_pkg::CYC_TWO; // RULE15
      end else if (cls.two_word) begin
        next_cur.phase = insn_decode_pkg::ph_second;
        next_cur.first_word = INSN_IN;
        next_cur.pend_op = cls.op;
      end else begin
        next_cur.phase = insn_decode_pkg::ph_first;
        next_cur.dec_valid = 1'b1;
        next_cur.dec = base_fields(INSN_IN, BANK_SELECT_IN);
        next_cur.dec.op = cls.op; // RULE16
        next_cur.dec.flag_mask = cls.flag_mask;
        next_cur.dec.can_skip = cls.can_skip; // RULE11
        next_cur.dec.cycles = cls.cycles; // RULE15
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cur <= insn_decode_pkg::STATE_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign DEC_OUT = cur.dec;
  assign DEC_VALID_OUT = cur.dec_valid;

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RSTN_IN);

  sequence s_single_word;
    INSN_VALID_IN && !cls.two_word &&
    !(cur.phase == insn_decode_pkg::ph_second && second_word);
  endsequence

  sequence s_first_half;
    INSN_VALID_IN && cls.two_word &&
    !(cur.phase == insn_decode_pkg::ph_second && second_word);
  endsequence

  sequence s_second_half;
    INSN_VALID_IN && cur.phase == insn_decode_pkg::ph_second && second_word;
  endsequence

  a_byte_fields: assert property ( // RULE1
    s_single_word |=> DEC_VALID_OUT &&
      DEC_OUT.opcode == $past(INSN_IN[15:10]) &&
      DEC_OUT.file_addr == $past(INSN_IN[7:0]))
    else $error("byte fields not split as expected");

  a_dest_select: assert property ( // RULE2
    s_single_word |=> DEC_OUT.dest_file == $past(INSN_IN[9]))
    else $error("destination bit wrong");

  a_bank_addr: assert property ( // RULE3
    s_single_word |=> DEC_OUT.eff_addr == ($past(INSN_IN[8]) ?
      {$past(BANK_SELECT_IN), $past(INSN_IN[7:0])} :
      {4'h0, $past(INSN_IN[7:0])}))
    else $error("bank addressing wrong");

  a_bit_field: assert property ( // RULE4
    s_single_word |=> DEC_OUT.bit_pos == $past(INSN_IN[11:9]) &&
      DEC_OUT.bank_sel_en == $past(INSN_IN[8]))
    else $error("bit position wrong");

  a_literal_pass: assert property ( // RULE5
    s_single_word |=> DEC_OUT.literal == $past(INSN_IN[7:0]))
    else $error("literal altered");

  a_jump_target: assert property ( // RULE6
    s_second_half |=> DEC_VALID_OUT && DEC_OUT.target ==
      {$past(INSN_IN[11:0]), $past(cur.first_word[7:0])})
    else $error("jump target not assembled");

  a_move_two_cycles: assert property ( // RULE7
    s_second_half ##0
      (cur.pend_op == insn_decode_pkg::op_file_to_file_move) |=>
      DEC_OUT.op == insn_decode_pkg::op_file_to_file_move &&
      DEC_OUT.cycles == 2'h2 && DEC_OUT.flag_mask == 5'h00)
    else $error("file move decoded wrong");

  a_first_half_quiet: assert property ( // RULE7
    s_first_half |=> !DEC_VALID_OUT &&
      cur.phase == insn_decode_pkg::ph_second)
    else $error("first word of pair produced output");

  a_offset_sum: assert property ( // RULE8
    s_second_half ##0 INDEXED_IN |=> DEC_OUT.src_addr ==
      12'($past(SRC_PTR_IN) + {5'h00, $past(cur.first_word[6:0])}) &&
      DEC_OUT.dst_addr ==
      12'($past(DST_PTR_IN) + {5'h00, $past(INSN_IN[6:0])}))
    else $error("indexed address wrong");

  a_add_decode: assert property ( // RULE10
    s_single_word ##0 (INSN_IN[15:10] == 6'h09) |=>
      DEC_OUT.op == insn_decode_pkg::op_add_acc_to_file &&
      DEC_OUT.flag_mask == 5'h1F && DEC_OUT.cycles == 2'h1)
    else $error("add decoded wrong");

  a_compare_skip: assert property ( // RULE11
    s_single_word ##0 (INSN_IN[15:9] == 7'h31) |=>
      DEC_OUT.op == insn_decode_pkg::op_compare_skip_equal &&
      DEC_OUT.can_skip && DEC_OUT.flag_mask == 5'h00)
    else $error("compare skip decoded wrong");

  a_dec_skip_nz: assert property ( // RULE12
    s_single_word ##0 (INSN_IN[15:10] == 6'h13) |=>
      DEC_OUT.op == insn_decode_pkg::op_decrement_skip_nonzero &&
      DEC_OUT.can_skip && DEC_OUT.flag_mask == 5'h00)
    else $error("decrement skip decoded wrong");

  a_inc_decode: assert property ( // RULE13
    s_single_word ##0 (INSN_IN[15:10] == 6'h0A) |=>
      DEC_OUT.op == insn_decode_pkg::op_increment_file &&
      DEC_OUT.flag_mask == 5'h1F)
    else $error("increment decoded wrong");

  a_zero_file_flag: assert property ( // RULE14
    s_single_word ##0 (INSN_IN[15:9] == 7'h35) |=>
      DEC_OUT.op == insn_decode_pkg::op_zero_file &&
      DEC_OUT.flag_mask == 5'h04)
    else $error("clear file decoded wrong");

  a_lone_second_nop: assert property ( // RULE16
    INSN_VALID_IN && cur.phase == insn_decode_pkg::ph_first &&
      second_word |=> DEC_VALID_OUT &&
      DEC_OUT.op == insn_decode_pkg::op_nop && DEC_OUT.cycles == 2'h1)
    else $error("lone second word not a no-operation");

  a_idle_no_valid: assert property ( // RULE15
    !INSN_VALID_IN |=> !DEC_VALID_OUT)
    else $error("output without an instruction word");

  a_carry_add: assert property ( // RULE10
    s_single_word ##0 (INSN_IN[15:10] == 6'h08) |=>
      DEC_OUT.op == insn_decode_pkg::op_add_acc_carry_to_file &&
      DEC_OUT.flag_mask == 5'h1F && DEC_OUT.cycles == 2'h1)
    else $error("add with carry decoded wrong");

  a_cmp_less: assert property ( // RULE11
    s_single_word ##0 (INSN_IN[15:9] == 7'h30) |=>
      DEC_OUT.op == insn_decode_pkg::op_compare_skip_less &&
      DEC_OUT.can_skip && DEC_OUT.flag_mask == 5'h00)
    else $error("compare less decoded wrong");

  a_cmp_greater: assert property ( // RULE11
    s_single_word ##0 (INSN_IN[15:9] == 7'h32) |=>
      DEC_OUT.op == insn_decode_pkg::op_compare_skip_greater &&
      DEC_OUT.can_skip && DEC_OUT.flag_mask == 5'h00)
    else $error("compare greater decoded wrong");

  a_dec_decode: assert property ( // RULE12
    s_single_word ##0 (INSN_IN[15:10] == 6'h01) |=>
      DEC_OUT.op == insn_decode_pkg::op_decrement_file &&
      DEC_OUT.flag_mask == 5'h1F)
    else $error("decrement decoded wrong");

  a_dec_skip_z: assert property ( // RULE12
    s_single_word ##0 (INSN_IN[15:10] == 6'h0B) |=>
      DEC_OUT.op == insn_decode_pkg::op_decrement_skip_zero &&
      DEC_OUT.can_skip && DEC_OUT.flag_mask == 5'h00)
    else $error("decrement skip zero decoded wrong");

  a_inc_skip_z: assert property ( // RULE13
    s_single_word ##0 (INSN_IN[15:10] == 6'h0F) |=>
      DEC_OUT.op == insn_decode_pkg::op_increment_skip_zero &&
      DEC_OUT.can_skip && DEC_OUT.flag_mask == 5'h00)
    else $error("increment skip decoded wrong");

  a_and_decode: assert property ( // RULE14
    s_single_word ##0 (INSN_IN[15:10] == 6'h05) |=>
      DEC_OUT.op == insn_decode_pkg::op_and_acc_with_file &&
      DEC_OUT.flag_mask == 5'h05)
    else $error("and decoded wrong");

  a_or_decode: assert property ( // RULE14
    s_single_word ##0 (INSN_IN[15:10] == 6'h04) |=>
      DEC_OUT.op == insn_decode_pkg::op_or_acc_with_file &&
      DEC_OUT.flag_mask == 5'h05)
    else $error("or decoded wrong");

  a_comp_decode: assert property ( // RULE14
    s_single_word ##0 (INSN_IN[15:10] == 6'h07) |=>
      DEC_OUT.op == insn_decode_pkg::op_complement_file &&
      DEC_OUT.flag_mask == 5'h05)
    else $error("complement decoded wrong");

  a_move_file_op_decode: assert property ( // RULE14
    s_single_word ##0 (INSN_IN[15:10] == 6'h14) |=>
      DEC_OUT.op == insn_decode_pkg::op_move_file_op &&
      DEC_OUT.flag_mask == 5'h05)
    else $error("move file decoded wrong");

  a_literal_op: assert property ( // RULE5
    s_single_word ##0 (INSN_IN[15:8] == 8'h0F) |=>
      DEC_OUT.op == insn_decode_pkg::op_add_literal &&
      DEC_OUT.literal == $past(INSN_IN[7:0]))
    else $error("add literal decoded wrong");

  a_goto_pair: assert property ( // RULE6
    s_second_half ##0 (cur.pend_op == insn_decode_pkg::op_goto) |=>
      DEC_OUT.op == insn_decode_pkg::op_goto)
    else $error("goto pair decoded wrong");

  a_call_fast: assert property ( // RULE6
    s_second_half ##0 (cur.pend_op == insn_decode_pkg::op_call) |=>
      DEC_OUT.op == insn_decode_pkg::op_call &&
      DEC_OUT.fast == $past(cur.first_word[8]))
    else $error("call pair decoded wrong");

  a_move_direct: assert property ( // RULE7
    s_second_half ##0 !INDEXED_IN |=>
      DEC_OUT.src_addr == $past(cur.first_word[11:0]) &&
      DEC_OUT.dst_addr == $past(INSN_IN[11:0]))
    else $error("direct move addresses wrong");

  a_bit_skip: assert property ( // RULE4
    s_single_word ##0 (INSN_IN[15:13] == 3'h5) |=>
      DEC_OUT.op == insn_decode_pkg::op_bit_oriented && DEC_OUT.can_skip)
    else $error("bit test skip decoded wrong");

  a_nop_word: assert property ( // RULE15
    s_single_word ##0 (INSN_IN == 16'h0000) |=>
      DEC_OUT.op == insn_decode_pkg::op_nop && DEC_OUT.cycles == 2'h1)
    else $error("all-zero word not a no-operation");

  a_single_cycle: assert property ( // RULE15
    s_single_word |=> DEC_VALID_OUT && DEC_OUT.cycles == 2'h1)
    else $error("single word cycle count wrong");

  a_pair_cycles: assert property ( // RULE15
    s_second_half |=> DEC_OUT.cycles == 2'h2 && !DEC_OUT.can_skip)
    else $error("pair cycle count wrong");

endmodule : instruction_word_decoder

// [insn_decode_pkg.sv]
// Function
// RULE1 - Byte ops: opcode, dest, bank, address fields
// RULE2 - Dest bit zero accumulator, one file
// RULE3 - Bank bit zero access bank, else bank select
// RULE4 - Bit ops: opcode, bit position, bank, address
// RULE5 - Low byte literal passed through unchanged
// RULE6 - Jump and call build 20-bit target
// RULE7 - File move: two words, two cycles, no flags
// RULE8 - Seven-bit offsets added to pointers
// RULE9 - Don't-care bits never change decoding
// RULE10 - Add with carry and add decode, all flags
// RULE11 - Compare skips decode, no flags, may skip
// RULE12 - Decrement forms decode with flag behaviour
// RULE13 - Increment forms decode with flag behaviour
// RULE14 - Logic, move, clear decode, zero/negative flags (clear sets the zero flag only)
// RULE15 - Cycle counts: one, two when flow changes
// RULE16 - Lone second word executes as no-operation
package insn_decode_pkg;

  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int TARGET_W = 20;
  localparam int OSC_PER_CYCLE = 4;

  // Field positions
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 10;
  localparam int NIB_LO = 12;
  localparam int DEST_POS = 9;
  localparam int BANK_POS = 8;
  localparam int FAST_POS = 8;
  localparam int FILE_HI = 7;
  localparam int BITPOS_HI = 11;
  localparam int BITPOS_LO = 9;
  localparam int ADDR12_HI = 11;
  localparam int OFFS_HI = 6;
  localparam int PFX7_LO = 9;
  localparam int BYTE_HI_LO = 8;

  // Opcode values
  localparam logic [3:0] NIB_SECOND = 4'hF;
  localparam logic [3:0] NIB_FILE_MOVE = 4'hC;
  localparam logic [3:0] NIB_BIT_TOGGLE = 4'h7;
  localparam logic [3:0] NIB_BIT_SET = 4'h8;
  localparam logic [3:0] NIB_BIT_CLEAR = 4'h9;
  localparam logic [3:0] NIB_BIT_SKIP_SET = 4'hA;
  localparam logic [3:0] NIB_BIT_SKIP_CLR = 4'hB;
  localparam logic [7:0] BYTE_GOTO = 8'hEF;
  localparam logic [7:0] BYTE_ADD_LITERAL = 8'h0F;
  localparam logic [6:0] PFX_CALL = 7'h76;
  localparam logic [6:0] PFX_ZERO_FILE = 7'h35;
  localparam logic [6:0] PFX_CMP_LESS = 7'h30;
  localparam logic [6:0] PFX_CMP_EQUAL = 7'h31;
  localparam logic [6:0] PFX_CMP_GREATER = 7'h32;
  localparam logic [5:0] OPC_ADD_CARRY = 6'h08;
  localparam logic [5:0] OPC_ADD = 6'h09;
  localparam logic [5:0] OPC_AND = 6'h05;
  localparam logic [5:0] OPC_OR = 6'h04;
  localparam logic [5:0] OPC_COMPLEMENT = 6'h07;
  localparam logic [5:0] OPC_MOVE_FILE = 6'h14;
  localparam logic [5:0] OPC_DEC = 6'h01;
  localparam logic [5:0] OPC_DEC_SKIP_Z = 6'h0B;
  localparam logic [5:0] OPC_DEC_SKIP_NZ = 6'h13;
  localparam logic [5:0] OPC_INC = 6'h0A;
  localparam logic [5:0] OPC_INC_SKIP_Z = 6'h0F;
  localparam logic [15:0] WORD_NOP = 16'h0000;

  // Flag masks, order carry, digit carry, zero, overflow, negative
  localparam logic [4:0] FLAGS_ALL = 5'h1F;
  localparam logic [4:0] FLAGS_ZN = 5'h05;
  localparam logic [4:0] FLAGS_Z = 5'h04;
  localparam logic [4:0] FLAGS_NONE = 5'h00;

  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // Access bank number and offset padding
  localparam logic [BANK_W-1:0] BANK_ACCESS = 4'h0;
  localparam logic [4:0] OFFS_PAD = 5'h00;

  typedef enum logic [4:0] {
    op_unknown,
    op_nop,
    op_add_acc_carry_to_file,
    op_add_acc_to_file,
    op_and_acc_with_file,
    op_or_acc_with_file,
    op_complement_file,
    op_move_file_op,
    op_zero_file,
    op_compare_skip_less,
    op_compare_skip_equal,
    op_compare_skip_greater,
    op_decrement_file,
    op_decrement_skip_zero,
    op_decrement_skip_nonzero,
    op_increment_file,
    op_increment_skip_zero,
    op_bit_oriented,
    op_add_literal,
    op_goto,
    op_call,
    op_file_to_file_move
  } op_t;

  typedef enum logic {ph_first, ph_second} phase_t;

  typedef struct packed {
    op_t op;
    logic [4:0] flag_mask;
    logic can_skip;
    logic two_word;
    logic [1:0] cycles;
  } class_t;

  typedef struct packed {
    op_t op;
    logic [5:0] opcode;
    logic dest_file;
    logic bank_sel_en;
    logic fast;
    logic [7:0] file_addr;
    logic [ADDR_W-1:0] eff_addr;
    logic [2:0] bit_pos;
    logic [7:0] literal;
    logic [TARGET_W-1:0] target;
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic [4:0] flag_mask;
    logic can_skip;
    logic [1:0] cycles;
  } decoded_t;

  typedef struct packed {
    phase_t phase;
    logic [WORD_W-1:0] first_word;
    op_t pend_op;
    decoded_t dec;
    logic dec_valid;
  } core_state_t;

  localparam core_state_t STATE_RST = '0;

endpackage : insn_decode_pkg

// [insn_class_lookup.sv]
`timescale 1ns/100ps
module insn_class_lookup (
  input wire logic [15:0] word_in,
  output insn_decode_pkg::class_t cls_out
);

  // Field compares plus one full-word compare for WORD_NOP; don't-care positions never reach a compare
  always_comb begin // RULE9
    cls_out = '0;
    cls_out.op = insn_decode_pkg::op_unknown;
    cls_out.flag_mask = insn_decode_pkg::FLAGS_NONE;
    cls_out.cycles = insn_decode_pkg::CYC_ONE; // RULE15
    if (word_in[15:12] == insn_decode_pkg::NIB_SECOND) begin
      cls_out.op = insn_decode_pkg::op_nop; // RULE16
    end else if (word_in == insn_decode_pkg::WORD_NOP) begin
      cls_out.op = insn_decode_pkg::op_nop;
    end else if (word_in[15:12] == insn_decode_pkg::NIB_FILE_MOVE) begin
      cls_out.op = insn_decode_pkg::op_file_to_file_move; // RULE7
      cls_out.two_word = 1'b1;
      cls_out.cycles = insn_decode_pkg::CYC_TWO;
    end else if (word_in[15:8] == insn_decode_pkg::BYTE_GOTO) begin
      cls_out.op = insn_decode_pkg::op_goto; // RULE6
      cls_out.two_word = 1'b1;
      cls_out.cycles = insn_decode_pkg::CYC_TWO;
    end else if (word_in[15:9] == insn_decode_pkg::PFX_CALL) begin
      cls_out.op = insn_decode_pkg::op_call; // RULE6
      cls_out.two_word = 1'b1;
      cls_out.cycles = insn_decode_pkg::CYC_TWO;
    end else if (word_in[15:8] == insn_decode_pkg::BYTE_ADD_LITERAL) begin
      cls_out.op = insn_decode_pkg::op_add_literal; // RULE5
      cls_out.flag_mask = insn_decode_pkg::FLAGS_ALL;
    end else if (word_in[15:9] == insn_decode_pkg::PFX_ZERO_FILE) begin
      cls_out.op = insn_decode_pkg::op_zero_file; // RULE14
      cls_out.flag_mask = insn_decode_pkg::FLAGS_Z;
    end else if (word_in[15:9] == insn_decode_pkg::PFX_CMP_LESS) begin
      cls_out.op = insn_decode_pkg::op_compare_skip_less; // RULE11
      cls_out.can_skip = 1'b1;
    end else if (word_in[15:9] == insn_decode_pkg::PFX_CMP_EQUAL) begin
      cls_out.op = insn_decode_pkg::op_compare_skip_equal; // RULE11
      cls_out.can_skip = 1'b1;
    end else if (word_in[15:9] == insn_decode_pkg::PFX_CMP_GREATER) begin
      cls_out.op = insn_decode_pkg::op_compare_skip_greater; // RULE11
      cls_out.can_skip = 1'b1;
    end else begin
      case (word_in[15:10])
        insn_decode_pkg::OPC_ADD_CARRY: begin
          cls_out.op = insn_decode_pkg::op_add_acc_carry_to_file; // RULE10
          cls_out.flag_mask = insn_decode_pkg::FLAGS_ALL;
        end
        insn_decode_pkg::OPC_ADD: begin
          cls_out.op = insn_decode_pkg::op_add_acc_to_file; // RULE10
          cls_out.flag_mask = insn_decode_pkg::FLAGS_ALL;
        end
        insn_decode_pkg::OPC_AND: begin
          cls_out.op = insn_decode_pkg::op_and_acc_with_file; // RULE14
          cls_out.flag_mask = insn_decode_pkg::FLAGS_ZN;
        end
        insn_decode_pkg::OPC_OR: begin
          cls_out.op = insn_decode_pkg::op_or_acc_with_file; // RULE14
          cls_out.flag_mask = insn_decode_pkg::FLAGS_ZN;
        end
        insn_decode_pkg::OPC_COMPLEMENT: begin
          cls_out.op = insn_decode_pkg::op_complement_file; // RULE14
          cls_out.flag_mask = insn_decode_pkg::FLAGS_ZN;
        end
        insn_decode_pkg::OPC_MOVE_FILE: begin
          cls_out.op = insn_decode_pkg::op_move_file_op; // RULE14
          cls_out.flag_mask = insn_decode_pkg::FLAGS_ZN;
        end
        insn_decode_pkg::OPC_DEC: begin
          cls_out.op = insn_decode_pkg::op_decrement_file; // RULE12
          cls_out.flag_mask = insn_decode_pkg::FLAGS_ALL;
        end
        insn_decode_pkg::OPC_DEC_SKIP_Z: begin
          cls_out.op = insn_decode_pkg::op_decrement_skip_zero; // RULE12
          cls_out.can_skip = 1'b1;
        end
        insn_decode_pkg::OPC_DEC_SKIP_NZ: begin
          cls_out.op = insn_decode_pkg::op_decrement_skip_nonzero; // RULE12
          cls_out.can_skip = 1'b1;
        end
        insn_decode_pkg::OPC_INC: begin
          cls_out.op = insn_decode_pkg::op_increment_file; // RULE13
          cls_out.flag_mask = insn_decode_pkg::FLAGS_ALL;
        end
        insn_decode_pkg::OPC_INC_SKIP_Z: begin
          cls_out.op = insn_decode_pkg::op_increment_skip_zero; // RULE13
          cls_out.can_skip = 1'b1;
        end
        default: begin
          case (word_in[15:12])
            insn_decode_pkg::NIB_BIT_TOGGLE,
            insn_decode_pkg::NIB_BIT_SET,
            insn_decode_pkg::NIB_BIT_CLEAR: begin
              cls_out.op = insn_decode_pkg::op_bit_oriented; // RULE4
            end
            insn_decode_pkg::NIB_BIT_SKIP_SET,
            insn_decode_pkg::NIB_BIT_SKIP_CLR: begin
              cls_out.op = insn_decode_pkg::op_bit_oriented; // RULE4
              cls_out.can_skip = 1'b1;
            end
            default: begin
              cls_out.op = insn_decode_pkg::op_unknown;
            end
          endcase
        end
      endcase
    end
  end

endmodule : insn_class_lookup

// [prog_word_source.sv]
`timescale 1ns/100ps
module prog_word_source (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic fetch_in,
  input wire logic [15:0] word_in,
  output logic [15:0] insn_out,
  output logic valid_out
);
  // Presents one word a cycle after each fetch; stale words flip each cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      insn_out <= 16'hA5A5;
      valid_out <= 1'b0;
    end else if (fetch_in) begin
      insn_out <= word_in;
      valid_out <= 1'b1;
    end else begin
      insn_out <= ~insn_out;
      valid_out <= 1'b0;
    end
  end
endmodule : prog_word_source

// [instruction_word_decoder_tb_top.sv]
`timescale 1ns/100ps
module instruction_word_decoder_tb_top;
  typedef struct packed {
    logic [15:0] w;
    insn_decode_pkg::op_t op;
    logic [4:0] fm;
    logic sk;
  } row_t;
  row_t rows [21] = '{
    '{16'h21A5,insn_decode_pkg::op_add_acc_carry_to_file,5'h1F,1'h0},
    '{16'h2635,insn_decode_pkg::op_add_acc_to_file,5'h1F,1'h0},
    '{16'h1712,insn_decode_pkg::op_and_acc_with_file,5'h05,1'h0},
    '{16'h1003,insn_decode_pkg::op_or_acc_with_file,5'h05,1'h0},
    '{16'h1E44,insn_decode_pkg::op_complement_file,5'h05,1'h0},
    '{16'h5155,insn_decode_pkg::op_move_file_op,5'h05,1'h0},
    '{16'h6A77,insn_decode_pkg::op_zero_file,5'h04,1'h0},
    '{16'h6188,insn_decode_pkg::op_compare_skip_less,5'h00,1'h1},
    '{16'h6299,insn_decode_pkg::op_compare_skip_equal,5'h00,1'h1},
    '{16'h65AA,insn_decode_pkg::op_compare_skip_greater,5'h00,1'h1},
    '{16'h07BB,insn_decode_pkg::op_decrement_file,5'h1F,1'h0},
    '{16'h2CCC,insn_decode_pkg::op_decrement_skip_zero,5'h00,1'h1},
    '{16'h4FDD,insn_decode_pkg::op_decrement_skip_nonzero,5'h00,1'h1},
    '{16'h2AEE,insn_decode_pkg::op_increment_file,5'h1F,1'h0},
    '{16'h3DFF,insn_decode_pkg::op_increment_skip_zero,5'h00,1'h1},
    '{16'h9B42,insn_decode_pkg::op_bit_oriented,5'h00,1'h0},
    '{16'h0F7E,insn_decode_pkg::op_add_literal,5'h1F,1'h0},
    '{16'hF123,insn_decode_pkg::op_nop,5'h00,1'h0},
    '{16'hFFFF,insn_decode_pkg::op_nop,5'h00,1'h0},
    '{16'h0000,insn_decode_pkg::op_nop,5'h00,1'h0},
    '{16'hA3C1,insn_decode_pkg::op_bit_oriented,5'h00,1'h1}
  };
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic fetch = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [3:0] bank = 4'h0;
  logic indexed = 1'b0;
  logic [11:0] sptr = 12'h000;
  logic [11:0] dptr = 12'h000;
  logic [15:0] insn;
  logic insn_valid;
  insn_decode_pkg::decoded_t dec;
  logic dec_valid;
  int failures = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  prog_word_source i_src (.clk_in(clk), .rstn_in(rstn), .fetch_in(fetch),
    .word_in(word), .insn_out(insn), .valid_out(insn_valid));

  instruction_word_decoder i_dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
    .INSN_IN(insn), .INSN_VALID_IN(insn_valid), .BANK_SELECT_IN(bank),
    .INDEXED_IN(indexed), .SRC_PTR_IN(sptr), .DST_PTR_IN(dptr),
    .DEC_OUT(dec), .DEC_VALID_OUT(dec_valid));

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [15:0] w, input logic wt);
    bit got;
    got = 1'b0;
    @(posedge clk);
    fetch <= 1'b1;
    word <= w;
    bank <= w[3:0];
    @(posedge clk);
    fetch <= 1'b0;
    if (wt) begin
      for (int i = 0; i < 8 && !got; i++) begin
        @(posedge clk);
        #1;
        got = (dec_valid === 1'b1);
      end
      if (!got) begin
        failures++;
        $display("MISMATCH at %0t: no decode seen", $time);
        conclude();
      end
    end
  endtask : send

  task automatic pair(input logic [15:0] w1, input logic [15:0] w2,
      input insn_decode_pkg::op_t op, input logic [11:0] src,
      input logic [11:0] dst);
    send(w1, 1'b0);
    @(posedge clk);
    #1;
    check(dec_valid, 1'b0);
    send(w2, 1'b1);
    check(dec.op, op);
    check(dec.target, {w2[11:0], w1[7:0]});
    check(dec.cycles, 2'h2);
    check(dec.flag_mask, 5'h00);
    check(dec.fast, w1[8]);
    if (op == insn_decode_pkg::op_file_to_file_move) begin
      check(dec.src_addr, src);
      check(dec.dst_addr, dst);
    end
  endtask : pair

  initial begin
    repeat (10) @(posedge clk);
    check(dec_valid, 1'b0);
    check(dec, '0);
    rstn <= 1'b1;
    foreach (rows[k]) begin
      send(rows[k].w, 1'b1);
      check(dec.op, rows[k].op);
      check(dec.flag_mask, rows[k].fm);
      check(dec.can_skip, rows[k].sk);
      check(dec.cycles, 2'h1);
      check(dec.opcode, rows[k].w[15:10]);
      check(dec.dest_file, rows[k].w[9]);
      check(dec.file_addr, rows[k].w[7:0]);
      check(dec.eff_addr, rows[k].w[8] ? {rows[k].w[3:0], rows[k].w[7:0]} :
        {4'h0, rows[k].w[7:0]});
      check(dec.bank_sel_en, rows[k].w[8]);
      check(dec.bit_pos, rows[k].w[11:9]);
      check(dec.literal, rows[k].w[7:0]);
      @(posedge clk);
      #1;
      check(dec_valid, 1'b0);
    end
    $display("table test done");
    pair(16'hC123, 16'hF456, insn_decode_pkg::op_file_to_file_move,
      12'h123, 12'h456);
    pair(16'hEF34, 16'hF567, insn_decode_pkg::op_goto, 12'h000, 12'h000);
    pair(16'hEC12, 16'hFABC, insn_decode_pkg::op_call, 12'h000, 12'h000);
    pair(16'hED12, 16'hFABC, insn_decode_pkg::op_call, 12'h000, 12'h000);
    @(posedge clk);
    indexed <= 1'b1;
    sptr <= 12'h100;
    dptr <= 12'hFF0;
    pair(16'hC005, 16'hF07F, insn_decode_pkg::op_file_to_file_move,
      12'h105, 12'h06F);
    @(posedge clk);
    indexed <= 1'b0;
    $display("pair test done");
    send(16'hC123, 1'b0);
    send(16'h2635, 1'b1);
    check(dec.op, insn_decode_pkg::op_add_acc_to_file);
    send(16'hF456, 1'b1);
    check(dec.op, insn_decode_pkg::op_nop);
    check(dec.cycles, 2'h1);
    $display("abort test done");
    send(16'hEF34, 1'b0);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    check(dec, '0);
    check(dec_valid, 1'b0);
    @(posedge clk);
    rstn <= 1'b1;
    send(16'hF567, 1'b1);
    check(dec.op, insn_decode_pkg::op_nop);
    $display("reset test done");
    conclude();
  end
endmodule : instruction_word_decoder_tb_top
